//--- icp_defines.vh
`ifndef ICP_DEFINES_VH
`define ICP_DEFINES_VH
// How it works
// - eight serial channels, or seven plus parallel
// - threshold event when fill exceeds N
// - threshold above seven never raises event
// - hang enabled: empty read, full write stall
// - hang disabled: empty read, full write complete without stall
// - global DMA enable gates all DMA
// - overflow clear bit clears all overflow flags
// - port disabled admits no channel sample; core FIFO writes still push
// - three-bit format field per serial channel
// - format codes select justification and width
// - I2S/left modes take 24 or 31 bits plus side
// - channel enables count only with port enable
// - channel DMA enables need global DMA enable
// - ping-pong needs channel and global DMA enable
// - control register top bit flushes FIFO
// - threshold event serves core reads only
// - eight-entry FIFO, fill count zero to eight
// - port enable falling discards FIFO contents
// - flush bit self-clears, zeroes fill count
// - one sticky overflow flag per channel

// register offsets (byte addresses)
`define ICP_OFF_CTL0    8'h00
`define ICP_OFF_CTL1    8'h04
`define ICP_OFF_STAT    8'h08
`define ICP_OFF_FIFO    8'h0c
`define ICP_OFF_MODE    8'h10
// decoded register indices
`define ICP_RI_CTL0     3'h0
`define ICP_RI_CTL1     3'h1
`define ICP_RI_STAT     3'h2
`define ICP_RI_FIFO     3'h3
`define ICP_RI_MODE     3'h4
`define ICP_RI_NONE     3'h7
// control 0 fields
`define ICP_BHD_BIT     4
`define ICP_DMAEN_BIT   5
`define ICP_CLROVR_BIT  6
`define ICP_EN_BIT      7
`define ICP_FMT_LSB     8
// control 1 fields
`define ICP_CHDMA_LSB   8
`define ICP_PING_LSB    16
`define ICP_FLUSH_BIT   31
// reset values and limits
`define ICP_CHEN_RST    8'hff
`define ICP_CHDMA_RST   8'hff
`define ICP_NSET_MAX    4'h7
`define ICP_DEPTH       4'h8
// serial formats
`define ICP_FMT_LJ24    3'h0
`define ICP_FMT_I2S24   3'h1
`define ICP_FMT_LJ32    3'h2
`define ICP_FMT_I2S32   3'h3
`define ICP_FMT_RJ24    3'h4
`define ICP_FMT_RJ20    3'h5
`define ICP_FMT_RJ18    3'h6
`define ICP_FMT_RJ16    3'h7
`endif

//--- icp_fifo_mem.v
`timescale 1ns/100ps
module icp_fifo_mem (
   input  wire        clock,   // system clock
   input  wire        sys_rst, // async reset, high
   input  wire        clkEn,   // freezes state when low
   input  wire        we,      // write strobe
   input  wire [2:0]  wAddr,   // write slot
   input  wire [31:0] wData,   // write word
   input  wire [2:0]  rAddr,   // head slot
   output reg  [31:0] rData    // registered head word
);
   reg [31:0] mem [0:7];       // eight sample slots

   // storage itself needs no reset
   always @(posedge clock) begin
      if (clkEn && we) begin
         mem[wAddr] <= wData;
      end
   end

   // head word follows the read slot; bypass so a word
   // written into an empty FIFO is readable next cycle
   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rData <= 32'h0;
      end else if (clkEn) begin
         if (we && wAddr == rAddr) begin
            rData <= wData;
         end else begin
            rData <= mem[rAddr];
         end
      end
   end
endmodule

//--- icp_ser_src.sv
`timescale 1ns/100ps
module icp_ser_src (
   output logic sclk,  // bit clock, still outside frames
   output logic frame, // side clock, low = left
   output logic sd     // serial data, msb first
);
   // idle: clock low, frame on left, data parked
   initial begin
      sclk = 1'b0;
      frame = 1'b0;
      sd = 1'b0;
   end
   // one side of a frame, 80 ns bits, data moves while clock is low
   task automatic side(input logic [31:0] w, input logic lvl);
      for (int i = 31; i >= 0; i--) begin
         frame = lvl;
         sd = w[i];
         #40;
         sclk = 1'b1;
         #40;
         sclk = 1'b0;
      end
      // released line has no pull: park on the inverse of the last bit
      sd = ~w[0];
   endtask
endmodule

//--- icp_serial_rx.v
`timescale 1ns/100ps
`include "icp_defines.vh"
module icp_serial_rx (
   input  wire        clock,   // system clock
   input  wire        sys_rst, // async reset, high
   input  wire        clkEn,   // freezes state when low
   input  wire        sclkPin, // serial bit clock pin
   input  wire        lrPin,   // frame / side pin
   input  wire        sdPin,   // serial data pin
   input  wire [2:0]  fmt,     // input format
   output reg         wordStb, // one-cycle new word
   output reg  [31:0] word     // held captured word
);
   reg        sclkS1, sclkS2, sclkS3; // clock sync + history
   reg        lrS1, lrS2;             // side sync
   reg        sdS1, sdS2;             // data sync
   reg [31:0] shift_reg;              // last 32 bits seen
   reg        lrPrev_reg;             // side at last bit
   reg        lrWord_reg;             // side of word pending
   reg        i2sPend_reg;            // i2s one-bit delay
   wire       rise = sclkS2 & ~sclkS3; // bit clock edge
   wire       isI2s = (fmt == `ICP_FMT_I2S24) ||
                      (fmt == `ICP_FMT_I2S32);

   // align the last 32 bits of a half frame per format
   function [31:0] packWord;
      input [31:0] s;
      input        lr;
      input [2:0]  f;
      begin
         case (f)
            `ICP_FMT_LJ24,
            `ICP_FMT_I2S24: packWord = {s[31:8], 7'h00, lr};
            `ICP_FMT_LJ32,
            `ICP_FMT_I2S32: packWord = {s[31:1], lr};
            `ICP_FMT_RJ24:  packWord = {s[23:0], 8'h00};
            `ICP_FMT_RJ20:  packWord = {s[19:0], 12'h000};
            `ICP_FMT_RJ18:  packWord = {s[17:0], 14'h0000};
            default:        packWord = {s[15:0], 16'h0000};
         endcase
      end
   endfunction

   // pins cross two flops before any logic reads them
   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         sclkS1 <= 1'b0;
         sclkS2 <= 1'b0;
         sclkS3 <= 1'b0;
         lrS1   <= 1'b0;
         lrS2   <= 1'b0;
         sdS1   <= 1'b0;
         sdS2   <= 1'b0;
      end else if (clkEn) begin
         sclkS1 <= sclkPin;
         sclkS2 <= sclkS1;
         sclkS3 <= sclkS2;
         lrS1   <= lrPin;
         lrS2   <= lrS1;
         sdS1   <= sdPin;
         sdS2   <= sdS1;
      end
   end

   // shift on each bit clock rise; a side change ends a word
   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         shift_reg   <= 32'h0;
         lrPrev_reg  <= 1'b0;
         lrWord_reg  <= 1'b0;
         i2sPend_reg <= 1'b0;
         wordStb     <= 1'b0;
         word        <= 32'h0;
      end else if (clkEn) begin
         wordStb <= 1'b0;
         if (rise) begin
            shift_reg  <= {shift_reg[30:0], sdS2};
            lrPrev_reg <= lrS2;
            if (i2sPend_reg) begin
               // i2s last bit came one clock after the change
               i2sPend_reg <= 1'b0;
               wordStb     <= 1'b1;
               word        <= packWord(shift_reg, lrWord_reg, fmt);
            end else if (lrS2 != lrPrev_reg) begin
               lrWord_reg <= lrPrev_reg;
               if (isI2s) begin
                  i2sPend_reg <= 1'b1;
               end else begin
                  wordStb <= 1'b1;
                  word    <= packWord(shift_reg, lrPrev_reg, fmt);
               end
            end
         end
      end
   end
endmodule

//--- icp_top.v
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`include "icp_defines.vh"
module icp_top (
   input  wire        clock,       // system clock, 100 MHz
   input  wire        sys_rst,     // async reset, high
   input  wire        clkEn,       // freezes all state when low
   input  wire        psel,        // apb select
   input  wire        penable,     // apb access phase
   input  wire        pwrite,      // apb direction, 1 = write
   input  wire [7:0]  paddr,       // apb byte address
   input  wire [31:0] pwdata,      // apb write data
   output reg  [31:0] prdata,      // apb read data
   output reg         pready,      // apb transfer done
   output reg         pslverr,     // apb unmapped address
   input  wire [7:0]  serClk,      // serial bit clocks
   input  wire [7:0]  serFrame,    // serial side clocks
   input  wire [7:0]  serData,     // serial data lines
   input  wire [19:0] parData,     // parallel channel data
   input  wire        parStrobe,   // parallel latch strobe
   input  wire        dmaAck,      // dma takes head word
   output reg         dmaRequest,  // head word ready for dma
   output wire [31:0] dmaData,     // head word (mem register)
   output reg         fifoThresholdEvent, // fill above level
   output reg  [7:0]  dmaChanActive,  // channel dma allowed
   output reg  [7:0]  dmaPingActive   // channel ping-pong on
);
   // control registers
   reg [3:0]  nset_reg;            // threshold level
   reg        hangDis_reg;         // no stall on empty/full
   reg        gdma_reg;            // global dma enable
   reg        portEn_reg;          // global port enable
   reg [23:0] fmt_reg;             // eight 3-bit formats
   reg [7:0]  chEn_reg;            // channel enables
   reg [7:0]  chDma_reg;           // channel dma enables
   reg [7:0]  ping_reg;            // channel ping-pong enables
   reg        parSel_reg;          // channel 0 from parallel
   // state
   reg [7:0]  ovf_reg;             // sticky overflow flags
   reg [7:0]  pend_reg;            // captured, not yet stored
   reg [2:0]  wrPtr_reg;           // fifo write slot
   reg [2:0]  rdPtr_reg;           // fifo head slot
   reg [3:0]  count_reg;           // fill count 0..8
   reg        popLast_reg;         // head word still settling
   // parallel capture
   reg        pStbS1, pStbS2, pStbS3; // strobe sync + history
   reg [19:0] pDatS1, pDatS2;      // data sync
   reg [31:0] parWord_reg;         // captured parallel word
   reg        parStb_reg;          // parallel word pulse

   wire [255:0] rxWord;            // held words per channel
   wire [7:0]   rxStb;             // word pulses per channel
   wire [31:0]  memRd;             // registered head word

   // next values and decode
   reg [7:0]  srcStb;              // sample pulses after mux
   reg [7:0]  admit;               // pulses that may enter
   reg [2:0]  sel;                 // channel served this cycle
   reg [7:0]  selMask;             // one-hot of sel
   reg [31:0] selWord;             // sample of sel
   reg        chanPush, chanDrop;  // channel stored / dropped
   reg [2:0]  ri;                  // decoded register
   reg        acc;                 // access phase pending
   reg        ctl0Wr, ctl1Wr;      // control writes
   reg        coreWr, coreRd;      // fifo port accesses
   reg        corePush, corePop;   // fifo port moves data
   reg        done;                // finish this transfer
   reg        dmaPop;              // dma takes head
   reg        push, pop, flush;    // fifo actions
   reg [31:0] pushData;            // word to store
   reg [31:0] rdVal;               // read value
   reg [7:0]  ovf_next;
   reg [7:0]  pend_next;
   reg [3:0]  count_next;

   genvar g;

   // lowest pending channel wins the single write port
   function [2:0] firstSet;
      input [7:0] v;
      integer k;
      begin
         firstSet = 3'h0;
         for (k = 7; k >= 0; k = k - 1) begin
            if (v[k]) begin
               firstSet = k[2:0];
            end
         end
      end
   endfunction

   // address decode, shared by read and write paths
   function [2:0] regIndex;
      input [7:0] a;
      begin
         case (a)
            `ICP_OFF_CTL0: regIndex = `ICP_RI_CTL0;
            `ICP_OFF_CTL1: regIndex = `ICP_RI_CTL1;
            `ICP_OFF_STAT: regIndex = `ICP_RI_STAT;
            `ICP_OFF_FIFO: regIndex = `ICP_RI_FIFO;
            `ICP_OFF_MODE: regIndex = `ICP_RI_MODE;
            default:       regIndex = `ICP_RI_NONE;
         endcase
      end
   endfunction

   // one receiver per serial channel, each with its format
   generate
      for (g = 0; g < 8; g = g + 1) begin : gRx
         icp_serial_rx uRx (
            .clock   (clock),
            .sys_rst (sys_rst),
            .clkEn   (clkEn),
            .sclkPin (serClk[g]),
            .lrPin   (serFrame[g]),
            .sdPin   (serData[g]),
            .fmt     (fmt_reg[3*g+2:3*g]),
            .wordStb (rxStb[g]),
            .word    (rxWord[32*g+31:32*g])
         );
      end
   endgenerate

   // eight-slot sample store with registered head word
   icp_fifo_mem uMem (
      .clock   (clock),
      .sys_rst (sys_rst),
      .clkEn   (clkEn),
      .we      (push),
      .wAddr   (wrPtr_reg),
      .wData   (pushData),
      .rAddr   (rdPtr_reg),
      .rData   (memRd)
   );
   assign dmaData = memRd;

   // parallel pins synchronised, latched on strobe rise
   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         pStbS1      <= 1'b0;
         pStbS2      <= 1'b0;
         pStbS3      <= 1'b0;
         pDatS1      <= 20'h0;
         pDatS2      <= 20'h0;
         parWord_reg <= 32'h0;
         parStb_reg  <= 1'b0;
      end else if (clkEn) begin
         pStbS1     <= parStrobe;
         pStbS2     <= pStbS1;
         pStbS3     <= pStbS2;
         pDatS1     <= parData;
         pDatS2     <= pDatS1;
         parStb_reg <= pStbS2 & ~pStbS3;
         if (pStbS2 & ~pStbS3) begin
            // msb aligned, low bits cleared
            parWord_reg <= {pDatS2, 12'h000};
         end
      end
   end

   // sample path, fifo control and register port
   always @* begin
      // channel 0 is the parallel input when selected
      srcStb = rxStb;
      if (parSel_reg) begin
         srcStb[0] = parStb_reg;
      end
      admit = srcStb & chEn_reg & {8{portEn_reg}};
      sel     = firstSet(pend_reg);
      selMask = (pend_reg != 8'h00) ? (8'h01 << sel) : 8'h00;
      if (sel == 3'h0 && parSel_reg) begin
         selWord = parWord_reg;
      end else begin
         selWord = rxWord[{sel, 5'h00} +: 32];
      end
      chanPush = (pend_reg != 8'h00) && (count_reg != `ICP_DEPTH);
      chanDrop = (pend_reg != 8'h00) && (count_reg == `ICP_DEPTH);

      // register port
      acc    = psel & penable & ~pready;
      ri     = regIndex(paddr);
      ctl0Wr = acc & pwrite & (ri == `ICP_RI_CTL0);
      ctl1Wr = acc & pwrite & (ri == `ICP_RI_CTL1);
      coreWr = acc & pwrite & (ri == `ICP_RI_FIFO);
      coreRd = acc & ~pwrite & (ri == `ICP_RI_FIFO);
      dmaPop = dmaAck & dmaRequest;
      // channel samples own the write port first
      corePush = coreWr & (count_reg != `ICP_DEPTH) & ~chanPush;
      // a pop waits while the head word is settling
      corePop  = coreRd & (count_reg != 4'h0) & ~dmaPop &
                 ~popLast_reg;
      done = acc & ~(coreWr | coreRd);
      if (coreWr) begin
         // full and hang enabled: hold pready low
         done = corePush | ((count_reg == `ICP_DEPTH) &
                hangDis_reg);
      end
      if (coreRd) begin
         done = corePop | ((count_reg == 4'h0) &
                hangDis_reg);
      end

      flush = (ctl1Wr & pwdata[`ICP_FLUSH_BIT]) |
              (ctl0Wr & portEn_reg &
               ~pwdata[`ICP_EN_BIT]);
      push     = (chanPush | corePush) & ~flush;
      pushData = chanPush ? selWord : pwdata;
      pop      = (dmaPop | corePop) & ~flush;

      // fill count follows pushes and pops
      count_next = count_reg + {3'h0, push} - {3'h0, pop};
      if (flush) begin
         count_next = 4'h0;
      end

      // new arrivals queue; a second arrival before storage
      // overwrites the first, and a sample facing a full fifo is lost
      pend_next = (pend_reg & ~selMask) | admit;
      if (flush) begin
         pend_next = 8'h00;
      end
      ovf_next = ovf_reg;
      if (ctl0Wr && pwdata[`ICP_CLROVR_BIT]) begin
         ovf_next = 8'h00;
      end
      // set wins over clear in the same cycle
      ovf_next = ovf_next | (admit & pend_reg & ~selMask) |
                 (chanDrop ? selMask : 8'h00);

      // read data
      case (ri)
         `ICP_RI_CTL0: rdVal = {fmt_reg, portEn_reg, 1'b0,
                                gdma_reg, hangDis_reg, nset_reg};
         `ICP_RI_CTL1: rdVal = {8'h00, ping_reg, chDma_reg,
                                chEn_reg};
         `ICP_RI_STAT: rdVal = {count_reg, 3'h0, dmaChanActive,
                                1'b0, ovf_reg, dmaPingActive};
         `ICP_RI_FIFO: rdVal = corePop ? memRd : 32'h0;
         `ICP_RI_MODE: rdVal = {31'h0, parSel_reg};
         default:      rdVal = 32'h0;
      endcase
   end

   // control registers; flush and clear bits read as zero
   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         nset_reg    <= 4'h0;
         hangDis_reg <= 1'b0;
         gdma_reg    <= 1'b0;
         portEn_reg  <= 1'b0;
         fmt_reg     <= 24'h0;
         chEn_reg    <= `ICP_CHEN_RST;
         chDma_reg   <= `ICP_CHDMA_RST;
         ping_reg    <= 8'h00;
         parSel_reg  <= 1'b0;
      end else if (clkEn) begin
         if (ctl0Wr) begin
            nset_reg    <= pwdata[3:0];
            hangDis_reg <= pwdata[`ICP_BHD_BIT];
            gdma_reg    <= pwdata[`ICP_DMAEN_BIT];
            portEn_reg  <= pwdata[`ICP_EN_BIT];
            fmt_reg     <= pwdata[31:`ICP_FMT_LSB];
         end
         if (ctl1Wr) begin
            chEn_reg  <= pwdata[7:0];
            chDma_reg <= pwdata[`ICP_CHDMA_LSB+7:`ICP_CHDMA_LSB];
            ping_reg  <= pwdata[`ICP_PING_LSB+7:`ICP_PING_LSB];
         end
         if (acc && pwrite && ri == `ICP_RI_MODE) begin
            parSel_reg <= pwdata[0];
         end
      end
   end

   // fifo pointers, count and flags
   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         ovf_reg     <= 8'h00;
         pend_reg    <= 8'h00;
         wrPtr_reg   <= 3'h0;
         rdPtr_reg   <= 3'h0;
         count_reg   <= 4'h0;
         popLast_reg <= 1'b0;
      end else if (clkEn) begin
         ovf_reg     <= ovf_next;
         pend_reg    <= pend_next;
         count_reg   <= count_next;
         popLast_reg <= pop;
         if (flush) begin
            wrPtr_reg <= 3'h0;
            rdPtr_reg <= 3'h0;
         end else begin
            if (push) begin
               wrPtr_reg <= wrPtr_reg + 3'h1;
            end
            if (pop) begin
               rdPtr_reg <= rdPtr_reg + 3'h1;
            end
         end
      end
   end

   // apb answer: one registered ready per finished access
   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (clkEn) begin
         pready  <= done;
         pslverr <= done & (ri == `ICP_RI_NONE);
         if (done && !pwrite) begin
            prdata <= rdVal;
         end
      end
   end

   // dma and threshold outputs
   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         dmaRequest         <= 1'b0;
         fifoThresholdEvent <= 1'b0;
         dmaChanActive      <= 8'h00;
         dmaPingActive      <= 8'h00;
      end else if (clkEn) begin
         // level for core polling only; dma uses its request
         fifoThresholdEvent <= (nset_reg <= `ICP_NSET_MAX) &&
                               (count_next > nset_reg);
         dmaChanActive <= chDma_reg &
                          {8{portEn_reg & gdma_reg}};
         dmaPingActive <= ping_reg & chDma_reg &
                          {8{portEn_reg & gdma_reg}};
         // drop after a pop until the new head has settled
         dmaRequest <= portEn_reg & gdma_reg &
                       (chDma_reg != 8'h00) &
                       (count_next != 4'h0) &
                       ~pop & ~popLast_reg & ~flush;
      end
   end
endmodule

//--- icp_top_asserts.sv
`timescale 1ns/100ps
module icp_top_asserts (
   input wire logic        clock,              // system clock
   input wire logic        sys_rst,            // async reset
   input wire logic        psel,               // apb select
   input wire logic        penable,            // apb access
   input wire logic        pwrite,             // apb direction
   input wire logic [7:0]  paddr,              // apb address
   input wire logic [31:0] pwdata,             // apb write data
   input wire logic [31:0] prdata,             // apb read data
   input wire logic        pready,             // apb done
   input wire logic        dmaRequest,         // dma head ready
   input wire logic        fifoThresholdEvent, // fill above level
   input wire logic [7:0]  dmaChanActive,      // dma allowed
   input wire logic [7:0]  dmaPingActive       // ping-pong on
);
   logic [7:0]  c0;  // control 0 low byte shadow
   logic [15:0] c1;  // channel dma and ping shadow
   logic        wrQ; // a write landed last edge
   wire         wr = psel && penable && pready && pwrite;
   wire  [7:0]  gate = c1[7:0] & {8{c0[7] & c0[5]}};
   // shadows track completed writes; design outputs lag one edge
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         c0 <= 8'h00;
         c1 <= 16'h00ff;
         wrQ <= 1'b0;
      end else begin
         wrQ <= wr;
         if (wr && paddr == 8'h00) c0 <= pwdata[7:0];
         if (wr && paddr == 8'h04) c1 <= pwdata[23:8];
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   property p_nohang;
      psel && penable && !pready && c0[4] && paddr == 8'h0c |-> ##[1:4] pready;
   endproperty
   a_nohang: assert property (p_nohang) else $error("fifo stall");
   property p_thr_off;
      c0[3:0] > 4'h7 && !wrQ |-> !fifoThresholdEvent;
   endproperty
   a_thr_off: assert property (p_thr_off) else $error("event");
   property p_gate;
      !wrQ |-> dmaChanActive == gate;
   endproperty
   a_gate: assert property (p_gate) else $error("dma gate");
   property p_ping;
      !wrQ |-> dmaPingActive == (gate & c1[15:8]);
   endproperty
   a_ping: assert property (p_ping) else $error("ping gate");
   property p_flush;
      wr && paddr == 8'h04 && pwdata[31] |-> ##3 !dmaRequest;
   endproperty
   a_flush: assert property (p_flush) else $error("flush");
   property p_dis;
      wr && paddr == 8'h00 && !pwdata[7] && c0[7] |-> ##3 !dmaRequest;
   endproperty
   a_dis: assert property (p_dis) else $error("disable flush");
   property p_count;
      pready && psel && !pwrite && paddr == 8'h08 |-> prdata[31:28] <= 4'h8;
   endproperty
   a_count: assert property (p_count) else $error("fill count");
   property p_req;
      dmaRequest && !wrQ |-> c0[7] && c0[5];
   endproperty
   a_req: assert property (p_req) else $error("dma request");
endmodule
bind icp_top icp_top_asserts i_icp_top_asserts (.clock(clock),
   .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .dmaRequest(dmaRequest), .fifoThresholdEvent(fifoThresholdEvent),
   .dmaChanActive(dmaChanActive), .dmaPingActive(dmaPingActive));

//--- tb.sv
`timescale 1ns/100ps
module tb;
   logic        clock = 0, sys_rst = 1;       // clock, reset
   logic        psel = 0, penable = 0, pwrite = 0; // apb request
   logic [7:0]  paddr = 0;                    // apb address
   logic [31:0] pwdata = 0, q, cfg = 0;       // data, result, formats
   logic        err, dmaAck = 0, pStb = 0;    // error, dma pop, strobe
   wire  [31:0] prdata, dmaData;              // read data, head
   wire         pready, pslverr, dmaRequest, fifoThresholdEvent;
   wire  [7:0]  dmaChanActive, dmaPingActive; // dma status
   wire         sclk, frame, sd;              // serial link
   int          fail_count = 0, cmp_count = 0, waitCyc, n;
   localparam logic [31:0] W = 32'ha5c39e17;  // sample
   // rows: channel format, shift and mask of the stored word
   logic [2:0]  fmtRow[8] = '{3'h2, 3'h0, 3'h4, 3'h5, 3'h6, 3'h7, 3'h1, 3'h3};
   int          shRow[8] = '{0, 0, 8, 12, 14, 16, 0, 0};
   logic [31:0] mkRow[8] = '{~32'h1, ~32'hff, '1, '1, '1, '1, ~32'hff, ~32'h1};
   always #5 clock = ~clock;
   icp_ser_src i_icp_ser_src (.sclk(sclk), .frame(frame), .sd(sd));
   // one source feeds all eight channels; formats tell them apart
   icp_top i_icp_top (.clock(clock), .sys_rst(sys_rst), .clkEn(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .serClk({8{sclk}}), .serFrame({8{frame}}),
      .serData({8{sd}}), .parData(20'habcde), .parStrobe(pStb),
      .dmaAck(dmaAck), .dmaRequest(dmaRequest), .dmaData(dmaData),
      .fifoThresholdEvent(fifoThresholdEvent),
      .dmaChanActive(dmaChanActive), .dmaPingActive(dmaPingActive));
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask
   // expected word of row i; i2s words end a bit late
   function automatic logic [31:0] ex(int i);
      return ((i > 5) ? {W[30:0], W[31]} : W) << shRow[i] & mkRow[i];
   endfunction
   // apb transfer: held until pready is sampled high, bounded wait
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock) penable <= 1'b1;
      waitCyc = 0;
      do begin
         @(posedge clock);
         waitCyc++;
      end while (pready !== 1'b1 && waitCyc < 3000);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (waitCyc >= 3000) begin
         $display("[FAIL] %0t apb timeout", $time);
         fail_count++;
         wrap_up();
      end
      @(posedge clock);
   endtask
   // left then right side; the left words land once right begins
   task automatic pair;
      i_icp_ser_src.side(W, 1'b0);
      i_icp_ser_src.side(W, 1'b1);
   endtask
   initial begin
      for (int i = 0; i < 8; i++) cfg[8 + 3 * i +: 3] = fmtRow[i];
      repeat (12) @(posedge clock);
      sys_rst <= 1'b0;
      apb(0, 8'h04, 0);
      chk(q, 32'h0000ffff);
      apb(0, 8'h14, 0);
      chk(32'(err), 1);
      apb(1, 8'h00, 32'h10);
      apb(0, 8'h0c, 0);
      chk(q, 0);
      apb(1, 8'h00, cfg | 32'h93);
      pair();
      apb(0, 8'h08, 0);
      chk(32'(q[31:28]), 8);
      chk(32'(fifoThresholdEvent), 1);
      i_icp_ser_src.side(W, 1'b0);
      apb(0, 8'h08, 0);
      chk(32'(q[15:8]), 32'hff);
      apb(1, 8'h00, cfg | 32'hd3);
      apb(0, 8'h08, 0);
      chk(32'(q[15:8]), 0);
      apb(1, 8'h0c, 32'h1234);
      for (int i = 0; i < 8; i++) begin
         apb(0, 8'h0c, 0);
         chk(q & mkRow[i], ex(i));
      end
      apb(1, 8'h00, cfg | 32'h88);
      for (int i = 0; i < 5; i++) apb(1, 8'h0c, i);
      apb(0, 8'h08, 0);
      chk(32'(q[31:28]), 5);
      chk(32'(fifoThresholdEvent), 0);
      apb(1, 8'h04, 32'h8000ffff);
      apb(0, 8'h08, 0);
      chk(32'(q[31:28]), 0);
      fork
         apb(0, 8'h0c, 0);
         begin
            repeat (50) @(posedge clock);
            pair();
         end
      join
      chk(32'(waitCyc > 50), 1);
      chk(q & mkRow[0], W & mkRow[0]);
      apb(1, 8'h04, 32'h000fffff);
      apb(1, 8'h00, cfg | 32'ha0);
      repeat (2) @(posedge clock);
      chk(32'(dmaChanActive), 32'hff);
      chk(32'(dmaPingActive), 32'h0f);
      n = 0;
      for (int k = 0; k < 400; k++) begin
         @(posedge clock);
         if (dmaAck && dmaRequest)
            chk(dmaData & mkRow[n + 1], ex(n + 1));
         n += int'(dmaAck && dmaRequest);
         dmaAck <= (dmaRequest === 1'b1) && !dmaAck;
      end
      chk(n, 7);
      apb(1, 8'h00, cfg | 32'h80);
      repeat (2) @(posedge clock);
      chk(32'(dmaChanActive), 0);
      apb(1, 8'h04, 32'h0000ff01);
      pair();
      apb(0, 8'h08, 0);
      chk(32'(q[31:28]), 2);
      apb(1, 8'h00, cfg);
      apb(0, 8'h08, 0);
      chk(32'(q[31:28]), 0);
      pair();
      apb(0, 8'h08, 0);
      chk(32'(q[31:28]), 0);
      apb(1, 8'h10, 1);
      apb(1, 8'h00, cfg | 32'h80);
      pStb <= 1'b1;
      repeat (4) @(posedge clock);
      pStb <= 1'b0;
      apb(0, 8'h0c, 0);
      chk(q, 32'habcde000);
      sys_rst <= 1'b1;
      @(posedge clock) sys_rst <= 1'b0;
      apb(0, 8'h04, 0);
      chk(q, 32'h0000ffff);
      wrap_up();
   end
endmodule
